// ==== core/dram_host_pkg.sv ====
// constants for the edo dram strobe controller
// Operation
// [RL1] twenty-bit address goes out as row half then column half on shared pins
// [RL2] device gates data bits 7..0 by lower strobe, 15..8 by upper strobe
// [RL3] device internal column strobe spans first fall to last rise
// [RL4] cycle starts at row strobe fall, ends when all three strobes high
// [RL5] controller keeps row active minimum time and precharges minimum time
// [RL6] read starts at later of column strobe or output gate fall, write high
// [RL7] device read data valid only after all access times met
// [RL8] write starts at later of column strobe and write strobe falls
// [RL9] controller drives write data before earlier of those falls; code drives it as write strobe falls, after column fall in read-modify-write
// [RL10] controller refreshes all 1024 rows within every 16 ms
// [RL11] device refreshes addressed row on any access or row-only cycle
// [RL12] row fall with column strobe low refreshes internal counter row
// [RL13] counter refresh does no data access, outputs stay high impedance
// [RL14] self refresh entered by counter refresh with row strobe held long
// [RL15] self refresh exit holds row strobe high a minimum time
// [RL16] after self refresh exit, burst refresh all rows unless distributed
// [RL17] device allows random column accesses within an open row
// [RL18] device holds page read data until next column strobe fall
// [RL19] device allows mixed reads and writes in one page
// [RL20] after power up wait 200 us then eight row strobe cycles
// [RL21] byte writes assert one column strobe; other lane not driven
// [RL22] counter refresh holds a column strobe low at row strobe fall
// [RL23] device in standby keeps data lines high impedance
// [RL24] read-modify-write reads with gate low, then gate high and write low
package dram_host_pkg;
   localparam int CLK_NS       = 5;
   localparam int T_RAS_NS     = 60;
   localparam int T_RP_NS      = 40;
   localparam int T_RCD_NS     = 15;
   localparam int T_CAS_NS     = 15;
   localparam int T_CP_NS      = 10;
   localparam int T_RAH_NS     = 10;
   localparam int T_CSR_NS     = 5;
   localparam int T_CHR_NS     = 10;
   localparam int T_RASS_NS    = 100000;
   localparam int T_RPS_NS     = 110;
   localparam int T_PWRUP_US   = 200;
   localparam int T_REF_MS     = 16;
   localparam int INIT_CYCLES  = 8;
   localparam int ROWS         = 1024;
   localparam int CLK_MHZ      = 1000 / CLK_NS;
   function automatic int up_cyc(input int ns);
      up_cyc = (ns + CLK_NS - 1) / CLK_NS;
      if (up_cyc < 1) up_cyc = 1;
   endfunction
   localparam int RAS_CYC  = up_cyc(T_RAS_NS);
   localparam int RP_CYC   = up_cyc(T_RP_NS);
   localparam int RCD_CYC  = up_cyc(T_RCD_NS);
   localparam int CAS_CYC  = up_cyc(T_CAS_NS);
   localparam int CP_CYC   = up_cyc(T_CP_NS);
   localparam int RAH_CYC  = up_cyc(T_RAH_NS);
   localparam int CSR_CYC  = up_cyc(T_CSR_NS);
   localparam int CHR_CYC  = up_cyc(T_CHR_NS);
   localparam int RPS_CYC  = up_cyc(T_RPS_NS);
   localparam int RASS_CYC = up_cyc(T_RASS_NS);
   localparam int PWRUP_CYC = T_PWRUP_US * CLK_MHZ;
   // interval per row, rounded down so the window is never exceeded
   localparam int REF_INT_CYC = (T_REF_MS * 1000 * CLK_MHZ) / ROWS;
   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_RMW   = 2'h2;
   localparam logic [1:0] OP_ROWREF = 2'h3;
endpackage

// ==== core/edo_dram_host.sv ====
// controller driving an edo page-mode dram through its strobe pins
`timescale 1ns/10ps
module edo_dram_host
   import dram_host_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC,
   parameter int REF_INTERVAL = REF_INT_CYC,
   parameter int SELF_HOLD    = RASS_CYC
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // user request
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_op,
   input  wire logic [19:0] req_addr,
   input  wire logic [15:0] req_wdata,
   input  wire logic [1:0]  req_lanes,
   input  wire logic        req_keep_row,
   input  wire logic        self_req,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic             init_done,
   output logic             in_self,
   // dram pins
   output logic             row_strobe_n,
   output logic             lower_col_strobe_n,
   output logic             upper_col_strobe_n,
   output logic             write_strobe_n,
   output logic             out_gate_n,
   output logic [9:0]       mux_addr_in,
   input  wire logic [15:0] dq_lines_in,
   output logic [15:0]      dq_lines_out,
   output logic [1:0]       dq_lines_oe_n
);
   typedef enum logic [11:0] {
      S_PWR   = 12'h001, S_IDLE = 12'h002, S_RAS  = 12'h004, S_CAS = 12'h008,
      S_RMWW  = 12'h010, S_CPRE = 12'h020, S_PRE  = 12'h040, S_CSR = 12'h080,
      S_CBR   = 12'h100, S_SELF = 12'h200, S_SEXIT = 12'h400, S_HOLD = 12'h800
   } st_t;
   st_t          st_r;
   logic [31:0]  cnt_r;
   logic [31:0]  ras_cnt_r;
   logic [31:0]  ref_cnt_r;
   logic [10:0]  ref_owed_r;
   logic [3:0]   init_cnt_r;
   logic [1:0]   op_r;
   logic [9:0]   row_r;
   logic         cbr_r;
   logic         burst_r;

   // row-active age, for minimum active time before ending a cycle
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         ras_cnt_r <= 32'h0;
      else if (ce)
         ras_cnt_r <= row_strobe_n ? 32'h0 : ras_cnt_r + 32'h1;

   // distributed refresh debt: one row owed per interval
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         ref_cnt_r  <= 32'h0;
         ref_owed_r <= 11'h0;
      end
      else if (ce)
      begin
         if (st_r == S_SEXIT && cnt_r == 32'h0)
            ref_owed_r <= 11'(ROWS); // RL16
         else if (st_r == S_SELF)
            ref_owed_r <= 11'h0;
         else
         begin
            ref_cnt_r <= (ref_cnt_r >= 32'(REF_INTERVAL - 1)) ? 32'h0 : ref_cnt_r + 32'h1;
            // a tick and a refresh done in the same cycle both count, so no debt is lost
            // power-up initialisation refreshes can run with nothing owed, so the debt must not wrap below zero
            ref_owed_r <= ref_owed_r + ((ref_cnt_r >= 32'(REF_INTERVAL - 1)) ? 11'h1 : 11'h0)
                        - ((st_r == S_CBR && cnt_r == 32'h0 && ref_owed_r != 11'h0)
                           ? 11'h1 : 11'h0); // RL10
         end
      end

   // main sequencer
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         st_r <= S_PWR; cnt_r <= 32'h0; init_cnt_r <= 4'h0; op_r <= OP_READ;
         row_r <= 10'h0; cbr_r <= 1'b0; burst_r <= 1'b0;
         row_strobe_n <= 1'b1; lower_col_strobe_n <= 1'b1; upper_col_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1; out_gate_n <= 1'b1; mux_addr_in <= 10'h0;
         dq_lines_out <= 16'h0; dq_lines_oe_n <= 2'h3; req_ready <= 1'b0;
         rsp_valid <= 1'b0; rsp_rdata <= 16'h0; init_done <= 1'b0; in_self <= 1'b0;
      end
      else if (ce)
      begin
         rsp_valid <= 1'b0;
         req_ready <= 1'b0;
         if (cnt_r != 32'h0)
            cnt_r <= cnt_r - 32'h1;
         else
            case (st_r)
               S_PWR:
               begin
                  cnt_r <= 32'(PWRUP_CYCLES); // RL20
                  st_r  <= S_PRE;
                  cbr_r <= 1'b0;
               end
               S_IDLE:
                  // a request met by ready is always taken, even if refresh fell due meanwhile
                  if (req_valid && req_ready)
                  begin
                     op_r  <= req_op;
                     row_r <= req_addr[19:10];
                     mux_addr_in <= req_addr[19:10]; // RL1
                     row_strobe_n <= 1'b0; // RL4
                     cnt_r <= 32'(RAH_CYC - 1);
                     st_r  <= S_RAS;
                     cbr_r <= 1'b0;
                  end
                  else if (init_cnt_r < 4'(INIT_CYCLES) || ref_owed_r != 11'h0)
                  begin
                     lower_col_strobe_n <= 1'b0; // RL22
                     upper_col_strobe_n <= 1'b0;
                     cbr_r <= 1'b1;
                     burst_r <= 1'b0;
                     cnt_r <= 32'(CSR_CYC - 1);
                     st_r  <= S_CSR;
                  end
                  else if (self_req)
                  begin
                     lower_col_strobe_n <= 1'b0;
                     upper_col_strobe_n <= 1'b0;
                     cbr_r <= 1'b1;
                     burst_r <= 1'b1;
                     cnt_r <= 32'(CSR_CYC - 1);
                     st_r  <= S_CSR;
                  end
                  else
                     req_ready <= 1'b1;
               S_RAS:
               begin
                  mux_addr_in <= req_addr[9:0]; // RL1
                  if (op_r == OP_ROWREF)
                  begin
                     cnt_r <= 32'(RAS_CYC - RAH_CYC - 1); // RL11
                     st_r  <= S_HOLD;
                  end
                  else
                  begin
                     if (op_r == OP_WRITE)
                     begin
                        write_strobe_n <= 1'b0; // RL8
                        dq_lines_out <= req_wdata; // RL9
                        dq_lines_oe_n <= ~req_lanes; // RL21
                     end
                     else
                        out_gate_n <= 1'b0; // RL6
                     cnt_r <= 32'(RCD_CYC - RAH_CYC);
                     st_r  <= S_CAS;
                  end
               end
               S_CAS:
                  if (lower_col_strobe_n && upper_col_strobe_n)
                  begin
                     lower_col_strobe_n <= ~req_lanes[0]; // RL21
                     upper_col_strobe_n <= ~req_lanes[1];
                     cnt_r <= 32'(CAS_CYC - 1);
                  end
                  else if (op_r == OP_RMW)
                  begin
                     rsp_rdata <= dq_lines_in;
                     out_gate_n <= 1'b1; // RL24
                     dq_lines_out <= req_wdata;
                     dq_lines_oe_n <= ~req_lanes;
                     cnt_r <= 32'(CAS_CYC - 1);
                     st_r  <= S_RMWW;
                  end
                  else
                  begin
                     if (op_r == OP_READ)
                        rsp_rdata <= dq_lines_in;
                     rsp_valid <= 1'b1;
                     lower_col_strobe_n <= 1'b1;
                     upper_col_strobe_n <= 1'b1;
                     write_strobe_n <= 1'b1;
                     dq_lines_oe_n <= 2'h3;
                     cnt_r <= 32'(CP_CYC - 1);
                     st_r  <= S_CPRE;
                  end
               S_RMWW:
                  if (write_strobe_n)
                  begin
                     write_strobe_n <= 1'b0; // RL24
                     cnt_r <= 32'(CAS_CYC - 1);
                  end
                  else
                  begin
                     rsp_valid <= 1'b1;
                     lower_col_strobe_n <= 1'b1;
                     upper_col_strobe_n <= 1'b1;
                     write_strobe_n <= 1'b1;
                     dq_lines_oe_n <= 2'h3;
                     cnt_r <= 32'(CP_CYC - 1);
                     st_r  <= S_CPRE;
                  end
               S_CPRE:
                  // page hit: next column in the same open row
                  if (req_keep_row && req_valid && req_addr[19:10] == row_r
                      && req_op != OP_ROWREF && ref_owed_r == 11'h0)
                  begin
                     op_r <= req_op;
                     st_r <= S_RAS;
                     out_gate_n <= 1'b1;
                  end
                  else
                  begin
                     out_gate_n <= 1'b1;
                     st_r <= S_HOLD;
                  end
               S_HOLD:
                  if (ras_cnt_r >= 32'(RAS_CYC)) // RL5
                  begin
                     row_strobe_n <= 1'b1;
                     lower_col_strobe_n <= 1'b1;
                     upper_col_strobe_n <= 1'b1;
                     cnt_r <= 32'(RP_CYC - 1); // RL5
                     st_r  <= S_PRE;
                  end
               S_PRE:
               begin
                  if (cbr_r && init_cnt_r < 4'(INIT_CYCLES))
                     init_cnt_r <= init_cnt_r + 4'h1;
                  init_done <= (init_cnt_r >= 4'(INIT_CYCLES)) ||
                               (cbr_r && init_cnt_r == 4'(INIT_CYCLES - 1));
                  cbr_r <= 1'b0;
                  st_r  <= S_IDLE;
               end
               S_CSR:
               begin
                  row_strobe_n <= 1'b0; // RL12
                  if (burst_r)
                  begin
                     cnt_r <= 32'(SELF_HOLD - 1); // RL14
                     st_r  <= S_SELF;
                  end
                  else
                  begin
                     cnt_r <= 32'(CHR_CYC - 1);
                     st_r  <= S_CBR;
                  end
               end
               S_CBR:
               begin
                  lower_col_strobe_n <= 1'b1; // RL13
                  upper_col_strobe_n <= 1'b1;
                  st_r <= S_HOLD;
               end
               S_SELF:
               begin
                  in_self <= 1'b1;
                  if (!self_req)
                  begin
                     row_strobe_n <= 1'b1; // RL15
                     lower_col_strobe_n <= 1'b1;
                     upper_col_strobe_n <= 1'b1;
                     cnt_r <= 32'(RPS_CYC - 1);
                     st_r  <= S_SEXIT;
                  end
               end
               S_SEXIT:
               begin
                  in_self <= 1'b0;
                  burst_r <= 1'b0;
                  st_r <= S_IDLE;
               end
               default:
                  st_r <= S_PWR;
            endcase
      end

   // row strobe never rises before minimum active time
   ras_min_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
      ($rose(row_strobe_n) && !in_self) |-> $past(ras_cnt_r) >= 32'(RAS_CYC))
      else $error("row strobe ended too early");
   // precharge held before next row strobe fall
   pre_min_a: assert property (@(posedge clk) disable iff (!rstn) // RL5
      ($rose(row_strobe_n) && ce) |=> row_strobe_n[*7])
      else $error("precharge too short");
   // counter refresh needs a column strobe low at row fall
   cbr_order_a: assert property (@(posedge clk) disable iff (!rstn) // RL22
      ($fell(row_strobe_n) && cbr_r) |-> !$past(lower_col_strobe_n))
      else $error("counter refresh without column strobe");
   // a write drives data no later than its column strobe
   wdata_a: assert property (@(posedge clk) disable iff (!rstn) // RL9
      ($fell(lower_col_strobe_n) && !write_strobe_n) |-> !dq_lines_oe_n[0])
      else $error("write data not driven");
   // undriven upper lane keeps its strobe high during a write
   byte_lane_a: assert property (@(posedge clk) disable iff (!rstn) // RL21
      (!write_strobe_n && dq_lines_oe_n[1]) |-> upper_col_strobe_n)
      else $error("upper lane strobed without data");
   // read has write strobe high and gate low at column fall
   read_cyc_a: assert property (@(posedge clk) disable iff (!rstn) // RL6
      ($fell(lower_col_strobe_n) && op_r == OP_READ && !cbr_r) |-> write_strobe_n && !out_gate_n)
      else $error("bad read strobes");
   // read-modify-write never has gate and write strobe low together
   rmw_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RL24
      !(out_gate_n == 1'b0 && write_strobe_n == 1'b0))
      else $error("gate and write strobe both low");
   // no access before initialisation
   init_first_a: assert property (@(posedge clk) disable iff (!rstn) // RL20
      (!init_done && $fell(row_strobe_n)) |-> cbr_r)
      else $error("access before initialisation");
endmodule // edo_dram_host

// ==== tb/dram_model.sv ====
// behavioural edo dram answering the strobe controller
`timescale 1ns/10ps
module dram_model (
   // strobes and address
   input  wire logic        row_strobe_n,
   input  wire logic        lower_col_strobe_n,
   input  wire logic        upper_col_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic        out_gate_n,
   input  wire logic [9:0]  mux_addr_in,
   // data side
   input  wire logic [15:0] dq_bus,
   input  wire logic        slow,
   output logic [15:0]      dev_dq,
   output logic [1:0]       dev_en
);
   logic [15:0] mem [int];
   logic [9:0]  row_r = 10'h000;
   logic [9:0]  col_r = 10'h000;
   logic [9:0]  ref_ctr = 10'h000;
   logic [15:0] rd_r = 16'h0000;
   logic [1:0]  lane_r = 2'h0;
   logic        cbr_r = 1'b0;
   logic        rd_ok = 1'b0;
   logic        hit_r = 1'b0;
   int          cbr_cnt = 0;
   int          row_only_cnt = 0;
   wire         cas_n = lower_col_strobe_n & upper_col_strobe_n;

   // unwritten cells read back a seed pattern
   function automatic logic [15:0] peek(input int a);
      return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a5a;
   endfunction

   // only strobed byte lanes take data
   task automatic wr;
      logic [15:0] v;
      v = peek({row_r, col_r});
      if (!lower_col_strobe_n) v[7:0] = dq_bus[7:0];
      if (!upper_col_strobe_n) v[15:8] = dq_bus[15:8];
      mem[{row_r, col_r}] = v;
   endtask

   // row fall with a column strobe already low uses the internal counter
   always @(negedge row_strobe_n)
   begin
      rd_ok = 1'b0;
      hit_r = 1'b0;
      cbr_r = !cas_n;
      if (!cas_n) ref_ctr = ref_ctr + 10'h001;
      if (!cas_n) cbr_cnt++;
      else row_r = mux_addr_in;
   end

   // row cycle without column access counts as a row-only refresh
   always @(posedge row_strobe_n) if (!cbr_r && !hit_r) row_only_cnt++;

   // column fall: latch column, then write or fetch read data
   always @(negedge cas_n) if (!row_strobe_n && !cbr_r)
   begin
      hit_r = 1'b1;
      col_r = mux_addr_in;
      lane_r = ~{upper_col_strobe_n, lower_col_strobe_n};
      rd_ok = 1'b0;
      if (!write_strobe_n) wr();
      else rd_r = peek({row_r, col_r});
      if (write_strobe_n) rd_ok <= #(slow ? 13 : 2) 1'b1;
   end

   // a late write strobe fall turns the read into a write
   always @(negedge write_strobe_n) if (!row_strobe_n && !cas_n && !cbr_r) wr();

   // drive only while selected; data held past the column rise
   assign dev_en = (!out_gate_n && write_strobe_n && rd_ok && !cbr_r
                    && !(row_strobe_n && cas_n)) ? lane_r : 2'h0;
   // released lanes show the inverse so a stale value never passes
   assign dev_dq = {dev_en[1] ? rd_r[15:8] : ~rd_r[15:8], dev_en[0] ? rd_r[7:0] : ~rd_r[7:0]};
endmodule // dram_model

// ==== tb/edo_dram_host_tb_top.sv ====
// self-checking bench for the edo dram strobe controller
`timescale 1ns/10ps
module edo_dram_host_tb_top;
   import dram_host_pkg::*;
   localparam int PWR   = 20;
   localparam int REFI  = 200;
   localparam int SELFH = 30;
   logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, slow = 1'b0;
   logic        req_valid = 1'b0, req_keep_row = 1'b0, self_req = 1'b0;
   logic [1:0]  req_op = 2'h0, req_lanes = 2'h0, dq_lines_oe_n, dev_en;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_wdata = 16'h0000, rsp_rdata, dq_lines_out, dev_dq, dq_bus, rd, e;
   logic        req_ready, rsp_valid, init_done, in_self, row_strobe_n, lower_col_strobe_n;
   logic        upper_col_strobe_n, write_strobe_n, out_gate_n;
   logic [9:0]  mux_addr_in;
   int          miscompares = 0, compares = 0, lo_n = 0, hi_n = 0, self_lo = 0, n0;
   logic [15:0] shadow [int];

   always #2.5 clk = ~clk;
   // per-lane wire: host while it drives, else the device
   assign dq_bus = {dq_lines_oe_n[1] ? dev_dq[15:8] : dq_lines_out[15:8],
                    dq_lines_oe_n[0] ? dev_dq[7:0] : dq_lines_out[7:0]};

   edo_dram_host #(.PWRUP_CYCLES(PWR), .REF_INTERVAL(REFI), .SELF_HOLD(SELFH))
   edo_dram_host_inst (.clk(clk), .rstn(rstn), .ce(ce), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
      .req_keep_row(req_keep_row), .self_req(self_req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done), .in_self(in_self),
      .row_strobe_n(row_strobe_n), .lower_col_strobe_n(lower_col_strobe_n),
      .upper_col_strobe_n(upper_col_strobe_n), .write_strobe_n(write_strobe_n),
      .out_gate_n(out_gate_n), .mux_addr_in(mux_addr_in), .dq_lines_in(dq_bus),
      .dq_lines_out(dq_lines_out), .dq_lines_oe_n(dq_lines_oe_n));
   dram_model dram_model_inst (.row_strobe_n(row_strobe_n),
      .lower_col_strobe_n(lower_col_strobe_n), .upper_col_strobe_n(upper_col_strobe_n),
      .write_strobe_n(write_strobe_n), .out_gate_n(out_gate_n), .mux_addr_in(mux_addr_in),
      .dq_bus(dq_bus), .slow(slow), .dev_dq(dev_dq), .dev_en(dev_en));

   task stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] ex(input int a);
      return shadow.exists(a) ? shadow[a] : a[15:0] ^ 16'h5a5a;
   endfunction

   function automatic logic sig(input int w);
      case (w)
         0: return req_ready;
         1: return rsp_valid;
         2: return init_done;
         default: return in_self;
      endcase
   endfunction

   // bounded wait on a design flag, sampled mid-cycle
   task wait_for(input int w, input logic lvl, input int lim);
      int n;
      n = 0;
      while (sig(w) !== lvl)
      begin
         @(negedge clk);
         n++;
         if (n > lim) chk(w, 32'hffff);
         if (n > lim) stop_test();
      end
   endtask

   // one request held until its answer; judges read data and cell contents
   task access(input logic [1:0] op, input int a, input logic [15:0] d,
               input logic [1:0] ln, input logic keep);
      @(posedge clk);
      #1;
      {req_valid, req_op, req_addr, req_wdata, req_lanes, req_keep_row} = {1'b1, op, a[19:0],
                                                                         d, ln, keep};
      e = ex(a);
      // row-only refresh gives no response; page hits are taken without ready
      if (op == OP_ROWREF)
      begin
         wait_for(0, 1'b1, 50000);
         @(posedge clk);
         #1 req_valid = 1'b0;
         @(negedge clk);
         wait_for(0, 1'b1, 200);
      end
      else
         wait_for(1, 1'b1, 50000);
      rd = rsp_rdata;
      if (op == OP_READ || op == OP_RMW) chk(rd, e);
      if (ln[0]) e[7:0] = d[7:0];
      if (ln[1]) e[15:8] = d[15:8];
      if (op == OP_WRITE || op == OP_RMW) shadow[a] = e;
      if (op != OP_ROWREF) chk(dram_model_inst.peek(a), ex(a));
   endtask

   task idle;
      @(posedge clk);
      #1 req_valid = 1'b0;
   endtask

   // row strobe run lengths, judged at each change of the strobe
   always @(negedge clk)
   begin
      if (!rstn) hi_n = RP_CYC;
      else if (!row_strobe_n)
      begin
         if (lo_n == 0) chk(hi_n >= (self_lo > SELFH ? RPS_CYC : RP_CYC), 1);
         lo_n++;
         hi_n = 0;
      end
      else
      begin
         if (lo_n > 0) chk(lo_n >= RAS_CYC, 1);
         if (lo_n > 0) self_lo = lo_n;
         hi_n++;
         lo_n = 0;
      end
   end

   task t_init;
      wait_for(2, 1'b1, PWR + 5000);
      chk(dram_model_inst.cbr_cnt >= INIT_CYCLES, 1);
   endtask

   // word, then lower and upper byte writes over it
   task t_bytes;
      access(OP_WRITE, 20'h12345, 16'hbeef, 2'h3, 1'b0);
      access(OP_READ, 20'h12345, 16'h0000, 2'h3, 1'b0);
      access(OP_WRITE, 20'h12345, 16'h22cc, 2'h1, 1'b0);
      access(OP_WRITE, 20'h12345, 16'hdd33, 2'h2, 1'b0);
      access(OP_READ, 20'h12345, 16'h0000, 2'h3, 1'b0);
      idle();
   endtask

   // mixed reads and writes in one row held open between accesses, slow device, column edges
   task t_page;
      slow = 1'b1;
      access(OP_WRITE, 20'h0a800, 16'h0101, 2'h3, 1'b1);
      access(OP_WRITE, 20'h0abff, 16'h0202, 2'h3, 1'b1);
      access(OP_READ, 20'h0a800, 16'h0000, 2'h3, 1'b1);
      access(OP_READ, 20'h0abff, 16'h0000, 2'h3, 1'b0);
      idle();
      slow = 1'b0;
   endtask

   task t_rmw_ref;
      access(OP_WRITE, 20'hfffff, 16'h5555, 2'h3, 1'b0);
      access(OP_RMW, 20'hfffff, 16'haaaa, 2'h3, 1'b0);
      idle();
      n0 = dram_model_inst.row_only_cnt;
      access(OP_ROWREF, 20'h3ff00, 16'h0000, 2'h3, 1'b0);
      idle();
      chk((dram_model_inst.row_only_cnt - n0) inside {[1:2]}, 1);
      n0 = dram_model_inst.cbr_cnt + dram_model_inst.row_only_cnt;
      repeat (10 * REFI) @(negedge clk);
      chk(dram_model_inst.cbr_cnt + dram_model_inst.row_only_cnt - n0 >= 9, 1);
   endtask

   // enter, hold, leave self refresh, then the owed burst
   task t_self;
      @(posedge clk);
      #1 self_req = 1'b1;
      wait_for(3, 1'b1, 2000);
      repeat (SELFH + 10) @(negedge clk);
      chk({row_strobe_n, dram_model_inst.cbr_r}, 2'h1);
      @(posedge clk);
      #1 self_req = 1'b0;
      wait_for(3, 1'b0, 2000);
      n0 = dram_model_inst.cbr_cnt + dram_model_inst.row_only_cnt;
      wait_for(0, 1'b1, 60000);
      chk(dram_model_inst.cbr_cnt + dram_model_inst.row_only_cnt - n0 >= ROWS, 1);
      access(OP_READ, 20'hfffff, 16'h0000, 2'h3, 1'b0);
      idle();
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      t_init();
      t_bytes();
      t_page();
      t_rmw_ref();
      t_self();
      stop_test();
   end

   // watchdog well beyond the expected run
   initial
   begin
      #400000;
      miscompares++;
      stop_test();
   end
endmodule // edo_dram_host_tb_top
